// File: logic/bfeb_unit.v
// Bitfield, extension and branch execution unit
`timescale 1ns/1ps
`include "bfeb_unit_regs.vh"

// Summary of operation
// - Field start 0..31, width 1..32-start accepted
// - Field clear zeroes selected bits only
// - Field insert copies low source bits
// - Signed extract sign-fills to 32 bits
// - Unsigned extract zero-fills to 32 bits
// - Field and extend ops keep flags
// - Rotate right 0/8/16/24 before extension
// - Signed byte extension of rotated bits
// - Unsigned byte extension of rotated bits
// - Signed halfword extension of rotated bits
// - Unsigned halfword extension of rotated bits
// - Register branch target clears bit zero
// - Linking branches write next address link
// - Register branch, bit zero clear: fault
// - Long branches +/-16MB, outside-block cond +/-1MB
// - Only conditional immediate branch outside block
// - In-block branch only as last instruction
// - Branches leave condition flags unchanged
// - Undefined register choices need no handling
module bfeb_unit #(
    parameter WIDTH = 32
) (
    input  wire                    clk_sys,
    input  wire                    reset_n,
    input  wire                    opValid,
    input  wire [3:0]              opCode,
    input  wire [4:0]              fieldLsb,
    input  wire [5:0]              fieldWidth,
    input  wire [1:0]              rotateSel,
    input  wire [3:0]              destIndex,
    input  wire [WIDTH-1:0]        destValue,
    input  wire [WIDTH-1:0]        fieldSourceOperand,
    input  wire [WIDTH-1:0]        secondSourceOperand,
    input  wire [WIDTH-1:0]        pcValue,
    input  wire                    wideInsn,
    input  wire [WIDTH-1:0]        branchOffset,
    input  wire                    condPass,
    input  wire                    inIfThenBlock,
    input  wire                    lastInBlock,
    input  wire [3:0]              flagsIn,
    output reg                     resultValid,
    output reg  [3:0]              resultIndex,
    output reg  [WIDTH-1:0]        resultData,
    output reg                     linkValid,
    output reg  [WIDTH-1:0]        linkData,
    output reg                     pcLoad,
    output reg  [WIDTH-1:0]        pcTarget,
    output reg  [3:0]              flagsOut,
    output reg                     invalidStateFault,
    output reg                     illegalOp
);

// ************************************************************
// Field mask and rotation
// ************************************************************

    // Field legal when width nonzero and start+width <= 32
    wire [6:0] fieldEnd = {2'b00, fieldLsb} + {1'b0, fieldWidth};
    wire       fieldOk  = (fieldWidth != 6'd0) &&
                          (fieldEnd <= 7'd32);
    wire [WIDTH-1:0] widthMask;
    reg  [WIDTH-1:0] fieldMask;
    reg  [WIDTH-1:0] rotated;
    reg  [WIDTH-1:0] shiftedDown;
    reg  [WIDTH-1:0] extracted;
    reg              topBit;
    genvar gi;

    // Low mask of fieldWidth ones, one bit per generate entry
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : gMask
            assign widthMask[gi] = (gi < fieldWidth);
        end
    endgenerate

    // Mask placed at start position, source shifted for extraction
    always @* begin
        fieldMask   = widthMask << fieldLsb;
        shiftedDown = fieldSourceOperand >> fieldLsb;
        extracted   = shiftedDown & widthMask;
        topBit      = shiftedDown[fieldWidth[4:0] - 5'd1];
        case (rotateSel)
            2'd1:    rotated = {secondSourceOperand[7:0],
                                secondSourceOperand[31:8]};
            2'd2:    rotated = {secondSourceOperand[15:0],
                                secondSourceOperand[31:16]};
            2'd3:    rotated = {secondSourceOperand[23:0],
                                secondSourceOperand[31:24]};
            default: rotated = secondSourceOperand;
        endcase
    end

// ************************************************************
// Branch target and range checks
// ************************************************************

    wire [WIDTH-1:0] immTarget = pcValue + branchOffset;
    wire [WIDTH-1:0] regTarget = {secondSourceOperand[WIDTH-1:1],
                                  1'b0};
    wire [WIDTH-1:0] nextAddr  = pcValue + (wideInsn ?
                                 `BFEB_INSN_WIDE : `BFEB_INSN_NARROW);
    // Signed offset range test: -lim <= off < lim
    wire offNeg = branchOffset[WIDTH-1];
    wire [WIDTH-1:0] offMag = offNeg ? (~branchOffset + 32'h0000_0001)
                                     : branchOffset;
    wire inLong  = offNeg ? (offMag <= `BFEB_RANGE_LONG)
                          : (offMag <  `BFEB_RANGE_LONG);
    wire inShort = offNeg ? (offMag <= `BFEB_RANGE_SHORT)
                          : (offMag <  `BFEB_RANGE_SHORT);

// ************************************************************
// Next state of the result outputs
// ************************************************************

    reg              next_resultValid;
    reg  [WIDTH-1:0] next_resultData;
    reg              next_linkValid;
    reg              next_pcLoad;
    reg  [WIDTH-1:0] next_pcTarget;
    reg              next_fault;
    reg              next_illegal;
    reg              isBranch;
    reg              isCondImm;
    reg              inRange;

    // Decode one operation; condition fail makes it a no-op apart from the branch placement checks
    always @* begin
        next_resultValid = 1'b0;
        next_resultData  = destValue;
        next_linkValid   = 1'b0;
        next_pcLoad      = 1'b0;
        next_pcTarget    = pcValue;
        next_fault       = 1'b0;
        next_illegal     = 1'b0;
        isBranch  = (opCode >= `BFEB_OP_BIMM) &&
                    (opCode <= `BFEB_OP_BLREG);
        isCondImm = (opCode == `BFEB_OP_BCOND);
        inRange   = (isCondImm && !inIfThenBlock) ? inShort
                                                  : inLong;
        if (opValid && condPass) begin
            case (opCode)
                `BFEB_OP_FCLR: begin
                    next_resultValid = fieldOk;
                    next_resultData  = destValue & ~fieldMask;
                end
                `BFEB_OP_FINS: begin
                    next_resultValid = fieldOk;
                    next_resultData  = (destValue & ~fieldMask) |
                        ((fieldSourceOperand << fieldLsb) &
                         fieldMask);
                end
                `BFEB_OP_SFX: begin
                    next_resultValid = fieldOk;
                    next_resultData  = extracted |
                        ({WIDTH{topBit}} & ~widthMask);
                end
                `BFEB_OP_UFX: begin
                    next_resultValid = fieldOk;
                    next_resultData  = extracted;
                end
                `BFEB_OP_SXB: begin
                    next_resultValid = 1'b1;
                    next_resultData  = {{24{rotated[7]}},
                                        rotated[7:0]};
                end
                `BFEB_OP_ZXB: begin
                    next_resultValid = 1'b1;
                    next_resultData  = {24'h00_0000,
                                        rotated[7:0]};
                end
                `BFEB_OP_SXH: begin
                    next_resultValid = 1'b1;
                    next_resultData  = {{16{rotated[15]}},
                                        rotated[15:0]};
                end
                `BFEB_OP_ZXH: begin
                    next_resultValid = 1'b1;
                    next_resultData  = {16'h0000,
                                        rotated[15:0]};
                end
                `BFEB_OP_BIMM, `BFEB_OP_BCOND, `BFEB_OP_BLIMM: begin
                    next_pcLoad    = inRange;
                    next_pcTarget  = immTarget;
                    next_linkValid = inRange &&
                        (opCode == `BFEB_OP_BLIMM);
                end
                `BFEB_OP_BREG, `BFEB_OP_BLREG: begin
                    if (!secondSourceOperand[0]) begin
                        next_fault = 1'b1;
                    end else begin
                        next_pcLoad    = 1'b1;
                        next_pcTarget  = regTarget;
                        next_linkValid = (opCode == `BFEB_OP_BLREG);
                    end
                end
                default: begin
                    next_resultValid = 1'b0;
                end
            endcase
            // Stack pointer or counter operands pass unchecked
            // Bad field or out-of-range immediate jump
            if (((opCode >= `BFEB_OP_FCLR) && (opCode <= `BFEB_OP_UFX)
                 && !fieldOk) ||
                (isBranch && opCode != `BFEB_OP_BREG &&
                 opCode != `BFEB_OP_BLREG && !inRange)) begin
                next_illegal = 1'b1;
            end
        end
        // Conditional-looking branch outside block or not last
        if (opValid && isBranch) begin
            if ((inIfThenBlock && !lastInBlock) ||
                (!inIfThenBlock && !condPass && !isCondImm)) begin
                next_illegal     = 1'b1;
                next_pcLoad      = 1'b0;
                next_linkValid   = 1'b0;
                next_fault       = 1'b0;
            end
        end
    end

// ************************************************************
// Output registers
// ************************************************************

    // Write strobe towards the register file
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            resultValid <= 1'b0;
        end else begin
            resultValid <= next_resultValid;
        end
    end

    // Destination index echoed beside the result
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            resultIndex <= 4'h0;
        end else begin
            resultIndex <= destIndex;
        end
    end

    // Result word; carries destination value when no field or extend op is decoded
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            resultData <= `BFEB_WORD_ZERO;
        end else begin
            resultData <= next_resultData;
        end
    end

    // Link write strobe, only for taken linking branches
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            linkValid <= 1'b0;
        end else begin
            linkValid <= next_linkValid;
        end
    end

    // Return address, recomputed every cycle
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            linkData <= `BFEB_WORD_ZERO;
        end else begin
            linkData <= nextAddr;
        end
    end

    // Program counter load strobe
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pcLoad <= 1'b0;
        end else begin
            pcLoad <= next_pcLoad;
        end
    end

    // New program counter value
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pcTarget <= `BFEB_RESET_PC;
        end else begin
            pcTarget <= next_pcTarget;
        end
    end

    // Flags pass through unchanged, one cycle late
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            flagsOut <= 4'h0;
        end else begin
            flagsOut <= flagsIn;
        end
    end

    // One-cycle pulse for a register branch to an even target
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            invalidStateFault <= 1'b0;
        end else begin
            invalidStateFault <= next_fault;
        end
    end

    // One-cycle pulse for a refused operation
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            illegalOp <= 1'b0;
        end else begin
            illegalOp <= next_illegal;
        end
    end

endmodule // bfeb_unit

// File: logic/bfeb_unit_regs.vh
// Operation codes and constants of the bitfield/branch unit
`ifndef BFEB_UNIT_REGS_VH
`define BFEB_UNIT_REGS_VH
// Operation codes (one-hot free encoding on opCode input)
`define BFEB_OP_WIDTH        4
`define BFEB_OP_NONE         4'h0
`define BFEB_OP_FCLR         4'h1
`define BFEB_OP_FINS         4'h2
`define BFEB_OP_SFX          4'h3
`define BFEB_OP_UFX          4'h4
`define BFEB_OP_SXB          4'h5
`define BFEB_OP_SXH          4'h6
`define BFEB_OP_ZXB          4'h7
`define BFEB_OP_ZXH          4'h8
`define BFEB_OP_BIMM         4'h9
`define BFEB_OP_BCOND        4'hA
`define BFEB_OP_BLIMM        4'hB
`define BFEB_OP_BREG         4'hC
`define BFEB_OP_BLREG        4'hD
// Branch offset limits in bytes (signed, +/-16 MB and +/-1 MB)
`define BFEB_RANGE_LONG      32'h0100_0000
`define BFEB_RANGE_SHORT     32'h0010_0000
// Link register index and reset values
`define BFEB_LINK_REG        4'hE
`define BFEB_RESET_PC        32'h0000_0000
`define BFEB_WORD_ZERO       32'h0000_0000
// Instruction sizes selectable for the return address
`define BFEB_INSN_NARROW     32'h0000_0002
`define BFEB_INSN_WIDE       32'h0000_0004
`endif

// File: tb/bfeb_core_model.sv
// Register file and program counter fed by the unit's write ports
`timescale 1ns/1ps
`include "bfeb_unit_regs.vh"
module bfeb_core_model (
    input wire        clk_sys,
    input wire        reset_n,
    input wire        resultValid,
    input wire [3:0]  resultIndex,
    input wire [31:0] resultData,
    input wire        linkValid,
    input wire [31:0] linkData,
    input wire        pcLoad,
    input wire [31:0] pcTarget
);
    reg [31:0] regs [0:15];
    reg [31:0] pc;
    // Write back results, link address and new program counter
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) pc <= `BFEB_RESET_PC;
        else begin
            if (resultValid) regs[resultIndex] <= resultData;
            if (linkValid) regs[`BFEB_LINK_REG] <= linkData;
            if (pcLoad) pc <= pcTarget;
        end
    end
endmodule // bfeb_core_model

// File: tb/bfeb_unit_bench.sv
// Self-checking bench of the bitfield, extension and branch unit
`timescale 1ns/1ps
`include "bfeb_unit_regs.vh"
module bfeb_unit_bench;
    reg        clk_sys = 1'b0, reset_n = 1'b0, opValid = 1'b0, wideInsn = 1'b0;
    reg        condPass = 1'b1, inIfThenBlock = 1'b0, lastInBlock = 1'b0;
    reg [3:0]  opCode = 4'h0, destIndex = 4'h0, flagsIn = 4'h0;
    reg [4:0]  fieldLsb = 5'h0;
    reg [5:0]  fieldWidth = 6'h0;
    reg [1:0]  rotateSel = 2'h0;
    reg [31:0] destValue = 32'h0, fieldSourceOperand = 32'h0;
    reg [31:0] secondSourceOperand = 32'h0, pcValue = 32'h0, branchOffset = 32'h0;
    wire       resultValid, linkValid, pcLoad, invalidStateFault, illegalOp;
    wire [3:0] resultIndex, flagsOut;
    wire [31:0] resultData, linkData, pcTarget;
    integer    err_total = 0, num_checks = 0, cycles = 0, i;
    bfeb_unit dut (.clk_sys(clk_sys), .reset_n(reset_n), .opValid(opValid),
        .opCode(opCode), .fieldLsb(fieldLsb), .fieldWidth(fieldWidth),
        .rotateSel(rotateSel), .destIndex(destIndex), .destValue(destValue),
        .fieldSourceOperand(fieldSourceOperand), .pcValue(pcValue),
        .secondSourceOperand(secondSourceOperand), .wideInsn(wideInsn),
        .branchOffset(branchOffset), .condPass(condPass), .flagsIn(flagsIn),
        .inIfThenBlock(inIfThenBlock), .lastInBlock(lastInBlock),
        .resultValid(resultValid), .resultIndex(resultIndex),
        .resultData(resultData), .linkValid(linkValid), .linkData(linkData),
        .pcLoad(pcLoad), .pcTarget(pcTarget), .flagsOut(flagsOut),
        .invalidStateFault(invalidStateFault), .illegalOp(illegalOp));
    bfeb_core_model model (.clk_sys(clk_sys), .reset_n(reset_n),
        .resultValid(resultValid), .resultIndex(resultIndex),
        .resultData(resultData), .linkValid(linkValid), .linkData(linkData),
        .pcLoad(pcLoad), .pcTarget(pcTarget));
    // Clock and hang limit
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 2000) begin err_total = err_total + 1; complete_run; end
    end
    task complete_run;
        if (err_total == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input [8*8:1] nm, input [31:0] e, input [31:0] g);
        begin
            if (g !== e) begin
                $display("MISMATCH %0s exp %h got %h", nm, e, g);
                err_total = err_total + 1;
            end
            num_checks = num_checks + 1;
        end
    endtask
    // One operation, outputs held for the caller to judge
    task go;
        begin
            @(negedge clk_sys);
            flagsIn = flagsIn + 4'h3;
            destIndex = opCode;
            opValid = 1'b1;
            @(negedge clk_sys);
            opValid = 1'b0;
            chk("flags", {28'h0, flagsIn}, {28'h0, flagsOut});
            chk("index", {28'h0, destIndex}, {28'h0, resultIndex});
        end
    endtask
    task fld(input [3:0] c, input [4:0] l, input [5:0] w, input [31:0] d,
             input [31:0] s);
        begin
            opCode = c; fieldLsb = l; fieldWidth = w;
            destValue = d; fieldSourceOperand = s;
            go;
        end
    endtask
    function [31:0] ext(input [3:0] c, input [1:0] r, input [31:0] v);
        reg [31:0] t;
        begin
            t = (v >> (8 * r)) | (v << (32 - 8 * r));
            case (c)
                `BFEB_OP_SXB: ext = {{24{t[7]}}, t[7:0]};
                `BFEB_OP_ZXB: ext = {24'h0, t[7:0]};
                `BFEB_OP_SXH: ext = {{16{t[15]}}, t[15:0]};
                default:      ext = {16'h0, t[15:0]};
            endcase
        end
    endfunction
    task t_fields;
        begin
            fld(`BFEB_OP_FCLR, 5'h8, 6'hC, 32'hFFFFFFFF, 32'h0);
            chk("clear", 32'hFFF000FF, resultData);
            fld(`BFEB_OP_FINS, 5'h8, 6'hC, 32'h0, 32'h12345ABC);
            chk("insert", 32'h000ABC00, resultData);
            fld(`BFEB_OP_FINS, 5'h1F, 6'h1, 32'h0, 32'h3);
            chk("ins_top", 32'h80000000, resultData);
            fld(`BFEB_OP_SFX, 5'h14, 6'h4, 32'h0, 32'h00800000);
            chk("sextract", 32'hFFFFFFF8, resultData);
            fld(`BFEB_OP_UFX, 5'h9, 6'hA, 32'h0, 32'hFFFFFFFF);
            chk("uextract", 32'h000003FF, resultData);
            fld(`BFEB_OP_UFX, 5'h0, 6'h20, 32'h0, 32'hDEADBEEF);
            chk("ufull", 32'hDEADBEEF, resultData);
            fld(`BFEB_OP_FCLR, 5'h1F, 6'h2, 32'h0, 32'h0);
            chk("badfield", 32'h1, {31'h0, illegalOp});
            chk("badwrite", 32'h0, {31'h0, resultValid});
            condPass = 1'b0;
            fld(`BFEB_OP_FCLR, 5'h0, 6'h4, 32'h0, 32'h0);
            chk("condfail", 32'h0, {31'h0, resultValid});
            condPass = 1'b1;
        end
    endtask
    task t_extend;
        for (i = 0; i < 16; i = i + 1) begin
            opCode = `BFEB_OP_SXB + i[3:2];
            rotateSel = i[1:0];
            secondSourceOperand = 32'h80FF7F01;
            go;
            chk("extend", ext(opCode, i[1:0], 32'h80FF7F01), resultData);
        end
    endtask
    task t_branch;
        begin
            pcValue = 32'h100; wideInsn = 1'b1; secondSourceOperand = 32'h1235;
            opCode = `BFEB_OP_BLREG; go;
            chk("regtgt", 32'h1234, pcTarget);
            chk("link", 32'h104, linkData);
            wideInsn = 1'b0; secondSourceOperand = 32'h2000;
            opCode = `BFEB_OP_BREG; go;
            chk("fault", 32'h1, {31'h0, invalidStateFault});
            chk("nojump", 32'h0, {31'h0, pcLoad});
            chk("lr", 32'h104, model.regs[`BFEB_LINK_REG]);
            chk("pc", 32'h1234, model.pc);
            opCode = `BFEB_OP_BLIMM; branchOffset = 32'h10; go;
            chk("linkimm", 32'h102, linkData);
            chk("linkwr", 32'h1, {31'h0, linkValid});
            opCode = `BFEB_OP_BCOND; branchOffset = `BFEB_RANGE_SHORT; go;
            chk("short", 32'h1, {31'h0, illegalOp});
            branchOffset = 32'h000FFFFE; go;
            chk("shortok", 32'h1, {31'h0, pcLoad});
            chk("immtgt", 32'h001000FE, pcTarget);
            branchOffset = 32'hFFF00000; go;
            chk("shortneg", 32'h1, {31'h0, pcLoad});
            inIfThenBlock = 1'b1; lastInBlock = 1'b1;
            branchOffset = `BFEB_RANGE_SHORT; go;
            chk("longin", 32'h1, {31'h0, pcLoad});
            lastInBlock = 1'b0; opCode = `BFEB_OP_BIMM; go;
            chk("notlast", 32'h1, {31'h0, illegalOp});
        end
    endtask
    initial begin
        repeat (6) @(negedge clk_sys);
        reset_n = 1'b1;
        t_fields;
        t_extend;
        t_branch;
        complete_run;
    end
endmodule // bfeb_unit_bench

// File: tb/bfeb_unit_checker.sv
// Concurrent checks on the ports of the bitfield and branch unit
`timescale 1ns/1ps
`include "bfeb_unit_regs.vh"
module bfeb_unit_checker (
    input wire        clk_sys,
    input wire        reset_n,
    input wire        opValid,
    input wire [3:0]  opCode,
    input wire [4:0]  fieldLsb,
    input wire [5:0]  fieldWidth,
    input wire [31:0] destValue,
    input wire [31:0] fieldSourceOperand,
    input wire [31:0] secondSourceOperand,
    input wire [31:0] pcValue,
    input wire        wideInsn,
    input wire [31:0] branchOffset,
    input wire        condPass,
    input wire        inIfThenBlock,
    input wire        lastInBlock,
    input wire [3:0]  flagsIn,
    input wire        resultValid,
    input wire [31:0] resultData,
    input wire        linkValid,
    input wire [31:0] linkData,
    input wire        pcLoad,
    input wire [31:0] pcTarget,
    input wire [3:0]  flagsOut,
    input wire        invalidStateFault,
    input wire        illegalOp
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Field masks and expected extract results
    wire [32:0] umFull = (33'h1 << fieldWidth) - 33'h1;
    wire [31:0] um = umFull[31:0];
    wire [31:0] m  = um << fieldLsb;
    wire [31:0] sh = fieldSourceOperand >> fieldLsb;
    wire [31:0] ux = sh & um;
    wire [31:0] sx = ux | (sh[fieldWidth - 6'd1] ? ~um : 32'h0);
    wire wok = fieldWidth != 6'd0 && fieldWidth <= 6'd32 - fieldLsb;
    wire go  = opValid && condPass;
    wire fop = go && opCode >= `BFEB_OP_FCLR && opCode <= `BFEB_OP_UFX;
    wire rop = go && !inIfThenBlock &&
        (opCode == `BFEB_OP_BREG || opCode == `BFEB_OP_BLREG);
    a_clear_field: assert property (fop && wok && opCode == `BFEB_OP_FCLR |=>
        resultValid && resultData == ($past(destValue) & ~$past(m)))
        else $error("field clear result wrong");
    a_insert_field: assert property (fop && wok && opCode == `BFEB_OP_FINS |=>
        resultData == ($past(destValue) & ~$past(m)
        | ($past(fieldSourceOperand) << $past(fieldLsb)) & $past(m)))
        else $error("field insert result wrong");
    a_signed_extract: assert property (fop && wok && opCode == `BFEB_OP_SFX
        |=> resultValid && resultData == $past(sx))
        else $error("signed extract result wrong");
    a_unsigned_extract: assert property (fop && wok && opCode == `BFEB_OP_UFX
        |=> resultValid && resultData == $past(ux))
        else $error("unsigned extract result wrong");
    a_bad_field: assert property (fop && !wok |=> illegalOp && !resultValid)
        else $error("bad field not refused");
    a_flags_kept: assert property (1'b1 |=> flagsOut == $past(flagsIn))
        else $error("flags changed");
    a_reg_target: assert property (rop && secondSourceOperand[0] |=>
        pcLoad && pcTarget == {$past(secondSourceOperand[31:1]), 1'b0})
        else $error("register target wrong");
    a_reg_fault: assert property (rop && !secondSourceOperand[0] |=>
        invalidStateFault && !pcLoad) else $error("missing fault");
    a_link_write: assert property (rop && opCode == `BFEB_OP_BLREG
        && secondSourceOperand[0] |=> linkValid && linkData ==
        $past(pcValue) + ($past(wideInsn) ? 32'h4 : 32'h2))
        else $error("link value wrong");
    a_short_range: assert property (go && !inIfThenBlock && opCode ==
        `BFEB_OP_BCOND && $signed(branchOffset) >= $signed(`BFEB_RANGE_SHORT)
        |=> illegalOp && !pcLoad) else $error("short range not refused");
    a_misplaced_branch: assert property (go && inIfThenBlock
        && !lastInBlock && opCode >= `BFEB_OP_BIMM
        && opCode <= `BFEB_OP_BLREG |=> illegalOp
        && !pcLoad && !linkValid) else $error("misplaced branch taken");
    c_field: cover property (fop && wok);
    c_fault: cover property (rop && !secondSourceOperand[0]);
    c_link: cover property (linkValid);
endmodule // bfeb_unit_checker
bind bfeb_unit bfeb_unit_checker chk (.*);
